//--- hw/msg_store.sv
// message buffer store with transmit selection and receive buffering
module msg_store
	import msg_store_pkg::*;
#(
	parameter logic [ADDR_W-1:0] BASE_ADDR = BASE_DEFAULT
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] host_addr,
	input  wire logic              host_sel,
	input  wire logic              host_wr,
	input  wire logic [7:0]        host_wdata,
	output logic [7:0]             host_rdata,
	output logic                   host_hit,
	input  wire logic [NUM_TX-1:0] tx_pending,
	input  wire logic              sof_req,
	output logic                   sel_valid,
	output logic [1:0]             sel_index,
	output logic                   sel_ide,
	output logic                   sel_rtr,
	output logic [28:0]            sel_ident,
	output logic [3:0]             sel_len_code,
	output logic [3:0]             sel_data_count,
	input  wire logic              sel_done,
	input  wire logic [3:0]        eng_tx_byte_idx,
	output logic [7:0]             eng_tx_byte,
	input  wire logic              rx_in_valid,
	output logic                   rx_in_ready,
	input  wire logic [3:0]        rx_in_idx,
	input  wire logic [7:0]        rx_in_byte,
	output logic                   rx_stall
);
	typedef struct packed {
		sel_state_t  st;
		logic [1:0]  idx;
		logic [1:0]  cnt;
		logic [1:0]  wp;
		logic [1:0]  rp;
		logic [3:0]  bidx0;
		logic [3:0]  bidx1;
		logic [7:0]  bdat0;
		logic [7:0]  bdat1;
		logic [7:0]  rdata;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	// frame record storage: slot 0 receive, 1..3 transmit; never reset
	logic [7:0] rec_mem [0:NUM_TX][0:REC_BYTES-1];
	logic [7:0] prio_ff [0:NUM_TX-1];

	function automatic logic [3:0] byte_count(input logic [3:0] code, input logic rtr);
		if (rtr)
			byte_count = 4'h0;
		else if (code > MAX_LEN)
			byte_count = MAX_LEN;
		else
			byte_count = code;
	endfunction

	logic       in_win;
	logic [2:0] slot;
	logic [3:0] boff;
	logic       is_rx;
	logic       is_tx;
	logic [1:0] tx_n;
	logic       host_we;
	logic       drain;
	logic [1:0] best;
	logic       any;
	logic [7:0] w1;
	logic [7:0] w3;
	logic       ide;

	assign in_win  = host_sel && (host_addr[ADDR_W-1:WIN_BITS] == BASE_ADDR[ADDR_W-1:WIN_BITS]);
	assign slot    = host_addr[6:4];
	assign boff    = host_addr[3:0];
	assign is_rx   = in_win && (slot == RX_SLOT);
	assign is_tx   = in_win && (slot >= TX0_SLOT);
	assign tx_n    = 2'(slot - TX0_SLOT);
	assign host_we = ce && host_wr && is_tx;
	assign host_hit = is_rx || is_tx;
	// ready drops with ce so a frozen buffer never swallows a byte it cannot store
	assign rx_in_ready = ce && (state_ff.cnt != 2'd2);
	assign drain   = (state_ff.cnt != 2'd0);
	assign rx_stall = !rx_in_ready;

	// pick the smallest priority among pending buffers; strict < keeps lowest index on ties
	always_comb begin
		best = 2'd0;
		any  = 1'b0;
		for (int i = 0; i < NUM_TX; i++) begin
			if (tx_pending[i] && (!any || prio_ff[i] < prio_ff[best])) begin
				best = 2'(i);
				any  = 1'b1;
			end
		end
	end

	// the selection is frozen for the whole frame so host rewrites of priority do not
	// swap buffers under the engine; the engine must hold sof_req only before sof
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff.st)
			SEL_IDLE: begin
				if (sof_req && any) begin
					nxt_state.st  = SEL_HOLD;
					nxt_state.idx = best;
				end
			end
			SEL_HOLD: begin
				if (sel_done)
					nxt_state.st = SEL_IDLE;
			end
		endcase
		// two-entry receive buffer
		if (rx_in_valid && rx_in_ready) begin
			if (state_ff.wp[0]) begin
				nxt_state.bidx1 = rx_in_idx;
				nxt_state.bdat1 = rx_in_byte;
			end else begin
				nxt_state.bidx0 = rx_in_idx;
				nxt_state.bdat0 = rx_in_byte;
			end
			nxt_state.wp = state_ff.wp + 2'd1;
		end
		if (drain)
			nxt_state.rp = state_ff.rp + 2'd1;
		nxt_state.cnt = 2'(state_ff.cnt + {1'b0, rx_in_valid && rx_in_ready} - {1'b0, drain});
		// host read data, registered
		nxt_state.rdata = 8'h00;
		if (host_sel && !host_wr && (is_rx || is_tx)) begin
			if (boff < 4'(REC_BYTES)) begin
				nxt_state.rdata = rec_mem[is_rx ? 2'd0 : 2'(tx_n + 2'd1)][boff];
				if (boff == LEN_BYTE)
					nxt_state.rdata = {4'h0, nxt_state.rdata[3:0]};
			end else if (boff == PRIO_BYTE && is_tx) begin
				nxt_state.rdata = prio_ff[tx_n];
			end
		end
		if (reset) begin
			nxt_state = '0;
			nxt_state.st = SEL_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (ce || reset)
			state_ff <= nxt_state;
	end

	// storage writes: host to transmit slots, receive buffer drains into slot 0
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_TX; i++)
				prio_ff[i] <= PRIO_RESET;
		end else if (ce) begin
			if (host_we && boff < 4'(REC_BYTES)) begin
				if (boff == LEN_BYTE)
					rec_mem[2'(tx_n + 2'd1)][boff] <= {4'h0, host_wdata[3:0] & LEN_MASK};
				else
					rec_mem[2'(tx_n + 2'd1)][boff] <= host_wdata;
			end
			if (host_we && boff == PRIO_BYTE)
				prio_ff[tx_n] <= host_wdata;
			if (drain) begin
				// srr, ide, rtr and identifier land as received
				if (state_ff.rp[0])
					rec_mem[0][state_ff.bidx1] <= state_ff.bdat1;
				else
					rec_mem[0][state_ff.bidx0] <= state_ff.bdat0;
			end
		end
	end

	// unpack the selected buffer's identifier
	assign w1  = rec_mem[2'(state_ff.idx + 2'd1)][1];
	assign w3  = rec_mem[2'(state_ff.idx + 2'd1)][3];
	assign ide = w1[IDE_BIT];

	always_ff @(posedge clk) begin
		if (reset) begin
			sel_valid      <= 1'b0;
			sel_index      <= 2'd0;
			sel_ide        <= 1'b0;
			sel_rtr        <= 1'b0;
			sel_ident      <= '0;
			sel_len_code   <= 4'h0;
			sel_data_count <= 4'h0;
			eng_tx_byte    <= 8'h00;
			host_rdata     <= 8'h00;
		end else if (ce) begin
			host_rdata <= nxt_state.rdata;
			sel_valid  <= (nxt_state.st == SEL_HOLD);
			sel_index  <= nxt_state.idx;
			if (state_ff.st == SEL_HOLD) begin
				sel_ide <= ide;
				if (ide) begin
					sel_rtr   <= w3[EXT_RTR_BIT];
					sel_ident <= {rec_mem[2'(state_ff.idx + 2'd1)][0], w1[7:5], w1[2:0],
						rec_mem[2'(state_ff.idx + 2'd1)][2], w3[7:1]};
				end else begin
					sel_rtr   <= w1[STD_RTR_BIT];
					sel_ident <= {18'h00000, rec_mem[2'(state_ff.idx + 2'd1)][0], w1[7:5]};
				end
				sel_len_code   <= rec_mem[2'(state_ff.idx + 2'd1)][LEN_BYTE][3:0];
				sel_data_count <= byte_count(rec_mem[2'(state_ff.idx + 2'd1)][LEN_BYTE][3:0],
					ide ? w3[EXT_RTR_BIT] : w1[STD_RTR_BIT]);
			end
			if (eng_tx_byte_idx < 4'(REC_BYTES))
				eng_tx_byte <= rec_mem[2'(state_ff.idx + 2'd1)][eng_tx_byte_idx];
			else
				eng_tx_byte <= 8'h00;
		end
	end

	chk_selection_lowest: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_IDLE && sof_req && any) |=> state_ff.idx == $past(best))
		else $error("selected buffer is not the best pending one");
	chk_select_pending: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_IDLE && sof_req && any) |-> tx_pending[best])
		else $error("selected a buffer that is not pending");
	chk_tie_low_index: assert property (@(posedge clk) disable iff (reset)
		(tx_pending[0] && any && prio_ff[0] <= prio_ff[best]) |-> best == 2'd0)
		else $error("tie not resolved to lowest index");
	chk_remote_zero: assert property (@(posedge clk) disable iff (reset)
		(sel_valid && sel_rtr) |-> sel_data_count == 4'h0)
		else $error("remote frame has nonzero data count");
	chk_count_bound: assert property (@(posedge clk) disable iff (reset)
		sel_data_count <= MAX_LEN)
		else $error("data count above eight");
	chk_rx_no_write: assert property (@(posedge clk) disable iff (reset)
		(host_sel && host_wr && is_rx) |-> !host_we)
		else $error("host write reached the receive buffer");
	chk_len_upper_zero: assert property (@(posedge clk) disable iff (reset)
		(ce && host_sel && !host_wr && host_hit && boff == LEN_BYTE) |=> host_rdata[7:4] == 4'h0)
		else $error("length byte upper bits not zero");
	chk_rx_prio_zero: assert property (@(posedge clk) disable iff (reset)
		(ce && host_sel && !host_wr && is_rx && boff == PRIO_BYTE) |=> host_rdata == 8'h00)
		else $error("receive buffer shows a priority byte");
	chk_buf_bound: assert property (@(posedge clk) disable iff (reset)
		state_ff.cnt <= 2'd2)
		else $error("receive buffer overfilled");
	cov_select: cover property (@(posedge clk) disable iff (reset) ce && sof_req && any);
	cov_tie: cover property (@(posedge clk) disable iff (reset)
		tx_pending == 3'b111 && prio_ff[0] == prio_ff[1]);
	cov_rx_full: cover property (@(posedge clk) disable iff (reset) rx_stall);
	cov_remote: cover property (@(posedge clk) disable iff (reset) sel_valid && sel_rtr);
	cov_extended: cover property (@(posedge clk) disable iff (reset) sel_valid && sel_ide);

	// helpers for the checks below
	logic [1:0] wslot;
	logic [3:0] drain_idx;
	logic [7:0] drain_dat;
	logic [7:0] w0;
	assign wslot     = 2'(tx_n + 2'd1);
	assign drain_idx = state_ff.rp[0] ? state_ff.bidx1 : state_ff.bidx0;
	assign drain_dat = state_ff.rp[0] ? state_ff.bdat1 : state_ff.bdat0;
	assign w0        = rec_mem[2'(state_ff.idx + 2'd1)][0];

	chk_window_miss: assert property (@(posedge clk) disable iff (reset)
		(host_sel && host_addr[ADDR_W-1:WIN_BITS] != BASE_ADDR[ADDR_W-1:WIN_BITS]) |-> !host_hit)
		else $error("access outside the window was claimed");
	chk_low_slots_miss: assert property (@(posedge clk) disable iff (reset)
		(in_win && slot < RX_SLOT) |-> !host_hit)
		else $error("non-buffer offset was claimed");
	chk_rx_slot_hit: assert property (@(posedge clk) disable iff (reset)
		(in_win && slot == RX_SLOT) |-> (host_hit && !is_tx))
		else $error("receive slot decoded wrongly");
	chk_tx_slot_hit: assert property (@(posedge clk) disable iff (reset)
		(in_win && slot >= TX0_SLOT && slot <= TX2_SLOT) |-> (host_hit && !is_rx))
		else $error("transmit slot decoded wrongly");
	chk_miss_reads_zero: assert property (@(posedge clk) disable iff (reset)
		(ce && host_sel && !host_wr && !host_hit) |=> host_rdata == 8'h00)
		else $error("read outside buffers returned data");
	chk_unused_zero: assert property (@(posedge clk) disable iff (reset)
		(ce && host_sel && !host_wr && host_hit && boff > PRIO_BYTE) |=> host_rdata == 8'h00)
		else $error("unused byte returned data");
	chk_prio_write: assert property (@(posedge clk) disable iff (reset)
		(ce && host_we && boff == PRIO_BYTE) |=> prio_ff[$past(tx_n)] == $past(host_wdata))
		else $error("priority write lost");
	chk_prio_read: assert property (@(posedge clk) disable iff (reset)
		(ce && host_sel && !host_wr && is_tx && boff == PRIO_BYTE) |=> host_rdata == $past(prio_ff[tx_n]))
		else $error("priority read wrong");
	chk_tx_store: assert property (@(posedge clk) disable iff (reset)
		(ce && host_we && boff < LEN_BYTE) |=> rec_mem[$past(wslot)][$past(boff)] == $past(host_wdata))
		else $error("transmit byte write lost");
	chk_len_store: assert property (@(posedge clk) disable iff (reset)
		(ce && host_we && boff == LEN_BYTE) |=> rec_mem[$past(wslot)][LEN_BYTE][7:4] == 4'h0)
		else $error("length byte stored upper bits");
	chk_rx_store: assert property (@(posedge clk) disable iff (reset)
		(ce && drain && drain_idx < 4'(REC_BYTES)) |=> rec_mem[0][$past(drain_idx)] == $past(drain_dat))
		else $error("received byte not stored as received");
	chk_rx_full_stall: assert property (@(posedge clk) disable iff (reset)
		(state_ff.cnt == 2'd2) |-> (!rx_in_ready && rx_stall))
		else $error("full receive buffer still ready");
	chk_rx_accept: assert property (@(posedge clk) disable iff (reset)
		(ce && rx_in_valid && rx_in_ready && !drain) |=> state_ff.cnt == 2'($past(state_ff.cnt) + 2'd1))
		else $error("accepted byte not counted");
	chk_ce_freeze: assert property (@(posedge clk) disable iff (reset)
		(!ce && !reset) |=> state_ff == $past(state_ff))
		else $error("state moved while clock enable low");
	chk_hold_frozen: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_HOLD && !sel_done) |=> (state_ff.st == SEL_HOLD && state_ff.idx == $past(state_ff.idx)))
		else $error("selection changed during a frame");
	chk_done_release: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_HOLD && sel_done) |=> (state_ff.st == SEL_IDLE && !sel_valid))
		else $error("frame end did not release selection");
	chk_no_pending_idle: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_IDLE && tx_pending == 3'b000) |=> !sel_valid)
		else $error("selection made with nothing pending");
	chk_valid_tracks: assert property (@(posedge clk) disable iff (reset)
		sel_valid == (state_ff.st == SEL_HOLD))
		else $error("valid out of step with selection state");
	chk_index_range: assert property (@(posedge clk) disable iff (reset)
		sel_valid |-> sel_index < 2'(NUM_TX))
		else $error("selected index out of range");
	chk_ext_ident: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_HOLD && ide) |=> (sel_ident[28:21] == $past(w0) && sel_ide))
		else $error("extended identifier top bits wrong");
	chk_std_ident: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_HOLD && !ide) |=> (sel_ident[28:11] == 18'h00000 && !sel_ide))
		else $error("standard identifier has high bits");
	chk_rtr_source: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_HOLD) |=> sel_rtr == $past(ide ? w3[EXT_RTR_BIT] : w1[STD_RTR_BIT]))
		else $error("frame type taken from wrong bit");
	chk_len_code: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_HOLD) |=> sel_len_code == $past(rec_mem[2'(state_ff.idx + 2'd1)][LEN_BYTE][3:0]))
		else $error("length code not passed as stored");
	chk_data_count: assert property (@(posedge clk) disable iff (reset)
		(!sel_rtr && sel_len_code <= MAX_LEN) |-> sel_data_count == sel_len_code)
		else $error("data count differs from length code");
	chk_data_cap: assert property (@(posedge clk) disable iff (reset)
		(!sel_rtr && sel_len_code > MAX_LEN) |-> sel_data_count == MAX_LEN)
		else $error("data count not capped at eight");
	chk_fetch_range: assert property (@(posedge clk) disable iff (reset)
		(ce && eng_tx_byte_idx >= 4'(REC_BYTES)) |=> eng_tx_byte == 8'h00)
		else $error("fetch past the record returned data");
	chk_fetch_byte: assert property (@(posedge clk) disable iff (reset)
		(ce && state_ff.st == SEL_HOLD && eng_tx_byte_idx < 4'(REC_BYTES))
		|=> eng_tx_byte == $past(rec_mem[2'(state_ff.idx + 2'd1)][eng_tx_byte_idx]))
		else $error("fetched byte differs from record");
endmodule

//--- shared/msg_store_pkg.sv
// constants and types for the message buffer store
// Functional notes
// - decode 128-byte window, base 128-aligned
// - receive buffer at window offset 0x40
// - transmit buffers at 0x50, 0x60, 0x70
// - 16-byte slot holds 13-byte frame record
// - priority byte at 0x0d, transmit only
// - frame record bytes not reset
// - receive buffer read-only, transmit read/write
// - extended identifier packing across four words
// - msb first, smaller identifier wins bus
// - host writes srr one; receive stores it
// - ide stored on receive, selects tx format
// - rtr stores/sets remote versus data frame
// - length code low nibble, upper reads zero
// - remote frame sends code, zero data
// - byte count follows the length code
// - lower local priority value ranks higher
// - select just before sof among pending
// - smallest local priority field wins
// - ties go to the lowest index
package msg_store_pkg;
	localparam int          ADDR_W       = 16;
	localparam int          WIN_BITS     = 7;
	localparam logic [6:0]  RX_SLOT_OFF  = 7'h40;
	localparam logic [6:0]  TX0_SLOT_OFF = 7'h50;
	localparam logic [2:0]  RX_SLOT      = 3'h4;
	localparam logic [2:0]  TX0_SLOT     = 3'h5;
	localparam logic [2:0]  TX2_SLOT     = 3'h7;
	localparam logic [3:0]  LEN_BYTE     = 4'hc;
	localparam logic [3:0]  PRIO_BYTE    = 4'hd;
	localparam int          REC_BYTES    = 13;
	localparam int          NUM_TX       = 3;
	localparam logic [3:0]  LEN_MASK     = 4'hf;
	localparam logic [3:0]  MAX_LEN      = 4'h8;
	localparam logic [7:0]  PRIO_RESET   = 8'h00;
	localparam logic [15:0] BASE_DEFAULT = 16'h0500;
	localparam int          SRR_BIT      = 4;
	localparam int          IDE_BIT      = 3;
	localparam int          STD_RTR_BIT  = 4;
	localparam int          STD_IDE_BIT  = 3;
	localparam int          EXT_RTR_BIT  = 0;

	typedef enum logic [1:0] {
		SEL_IDLE = 2'b00,
		SEL_HOLD = 2'b01
	} sel_state_t;
endpackage

//--- tb/eng_model.sv
// engine-side model: frame start, record fetch, frame end, receive bytes
module eng_model (
	input  wire logic       clk,
	input  wire logic       rx_ready,
	output logic            sof,
	output logic            done,
	output logic [3:0]      idx,
	output logic            rx_valid,
	output logic [3:0]      rx_idx,
	output logic [7:0]      rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {sof, done, idx, rx_valid, rx_idx, rx_byte} = '0;
	task automatic pulse_sof();
		@(posedge clk) #1 sof = 1;
		@(posedge clk) #1 sof = 0;
	endtask
	task automatic pulse_done();
		@(posedge clk) #1 done = 1;
		@(posedge clk) #1 done = 0;
	endtask
	task automatic fetch(logic [3:0] i);
		@(posedge clk) #1 idx = i;
	endtask
	// bytes stream back to back; valid holds until ready is seen
	task automatic rx_frame(logic [12:0][7:0] f);
		for (int i = 0; i < 13; i++) begin
			@(posedge clk) #1 {rx_valid, rx_idx, rx_byte} = {1'b1, 4'(i), f[i]};
			while (rx_ready !== 1'b1) @(posedge clk) #1;
		end
		@(posedge clk) #1 rx_valid = 0;
		rx_byte = ~rx_byte;
	endtask
endmodule

//--- tb/tb_msg_store.sv
// self-checking bench for the message buffer store
module tb_msg_store;
	import msg_store_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] BASE = 16'h0a80;
	typedef struct {string nm; logic [31:0] v;} exp_t;
	logic              clk, reset, ce, host_sel, host_wr, host_hit, probe;
	logic              sof_req, sel_valid, sel_ide, sel_rtr, sel_done;
	logic              rx_in_valid, rx_in_ready, rx_stall;
	logic [15:0]       host_addr;
	logic [7:0]        host_wdata, host_rdata, eng_tx_byte, rx_in_byte;
	logic [2:0]        tx_pending;
	logic [1:0]        sel_index;
	logic [28:0]       sel_ident;
	logic [3:0]        sel_len_code, sel_data_count, eng_tx_byte_idx, rx_in_idx;
	logic [7:0]        img [8][16];
	exp_t              q [$];
	int                mismatches, n_compared;
	msg_store #(.BASE_ADDR(BASE)) DUT (.clk, .reset, .ce, .host_addr, .host_sel, .host_wr,
		.host_wdata, .host_rdata, .host_hit, .tx_pending, .sof_req, .sel_valid, .sel_index,
		.sel_ide, .sel_rtr, .sel_ident, .sel_len_code, .sel_data_count, .sel_done,
		.eng_tx_byte_idx, .eng_tx_byte, .rx_in_valid, .rx_in_ready, .rx_in_idx, .rx_in_byte,
		.rx_stall);
	eng_model eng (.clk, .rx_ready(rx_in_ready), .sof(sof_req), .done(sel_done),
		.idx(eng_tx_byte_idx), .rx_valid(rx_in_valid), .rx_idx(rx_in_idx), .rx_byte(rx_in_byte));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic check(string nm, logic [31:0] got, logic [31:0] e);
		n_compared++;
		if (got !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", nm, e, got);
		end
	endtask
	function automatic logic [31:0] seen(string nm);
		case (nm)
			"rdata": return 32'(host_rdata);
			"hit":   return 32'(host_hit);
			"valid": return 32'(sel_valid);
			"index": return 32'(sel_index);
			"ident": return 32'(sel_ident);
			"ide":   return 32'(sel_ide);
			"rtr":   return 32'(sel_rtr);
			"len":   return 32'(sel_len_code);
			"count": return 32'(sel_data_count);
			default: return 32'(eng_tx_byte);
		endcase
	endfunction
	// results are taken once the edge's updates have landed
	initial forever begin
		@(posedge clk) #2;
		if (probe) begin
			probe = 0;
			while (q.size() > 0) begin
				exp_t e;
				e = q.pop_front();
				check(e.nm, seen(e.nm), e.v);
			end
		end
	end
	task automatic ex(string nm, logic [31:0] v);
		q.push_back('{nm, v});
	endtask
	task automatic wr(logic [6:0] off, logic [7:0] d);
		@(posedge clk) #1 {host_sel, host_wr, host_addr, host_wdata} = {2'b11, BASE + 16'(off), d};
		@(posedge clk) #1 host_sel = 0;
		if (off[6:4] > 4) img[off[6:4]][off[3:0]] = d;
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] e, logic h);
		@(posedge clk) #1 {host_sel, host_wr, host_addr} = {2'b10, a};
		@(posedge clk) #1;
		// hit is combinational, so the strobe stays up until the compare
		ex("rdata", 32'(e));
		ex("hit", 32'(h));
		probe = 1;
		@(posedge clk) #1 host_sel = 0;
	endtask
	function automatic logic [7:0] want(logic [6:0] off);
		logic [2:0] s = off[6:4];
		logic [3:0] b = off[3:0];
		if (s < 4 || b > 4'hd || (b == 4'hd && s == 4)) return 8'h00;
		return (b == 4'hc) ? (img[s][b] & 8'h0f) : img[s][b];
	endfunction
	task automatic pick(logic [2:0] pend, int k);
		logic [7:0] p [3];
		logic [7:0] r [16];
		logic [8:0] best;
		logic [1:0] win;
		logic [3:0] cnt;
		logic       ide, rtr;
		best = 9'h100;
		win = 0;
		for (int i = 0; i < 3; i++) begin
			p[i] = 8'($urandom % 3); // ties are frequent on purpose
			wr(7'(16 * i + 93), p[i]);
			if (pend[i] && p[i] < best) {best, win} = {1'b0, p[i], 2'(i)};
		end
		ide = k[0];
		rtr = k[1];
		wr(7'(16 * win + 81), {3'(k), ide ? 1'b1 : rtr, ide, 3'(k + 3)});
		wr(7'(16 * win + 83), {7'($urandom), rtr});
		wr(7'(16 * win + 92), 8'(k));
		@(posedge clk) #1 tx_pending = pend;
		eng.pulse_sof();
		ex("valid", 32'(pend != 0));
		ex("index", 32'(win));
		probe = 1;
		if (pend == 0) return;
		r = img[5 + win];
		cnt = rtr ? 4'h0 : (k > 8 ? 4'h8 : 4'(k));
		@(posedge clk) #1;
		ex("ident", ide ? 32'({r[0], r[1][7:5], r[1][2:0], r[2], r[3][7:1]})
			: 32'({r[0], r[1][7:5]}));
		ex("ide", 32'(ide));
		ex("rtr", 32'(rtr));
		ex("len", 32'(k));
		ex("count", 32'(cnt));
		probe = 1;
		for (int i = 0; i < cnt; i++) begin
			eng.fetch(4'(4 + i));
			@(posedge clk) #1;
			ex("byte", 32'(r[4 + i]));
			probe = 1;
		end
		eng.pulse_done();
		ex("valid", 0);
		probe = 1;
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// a full run takes about 800 cycles
	initial begin
		#400000;
		mismatches++;
		test_done();
	end
	initial begin
		logic [12:0][7:0] f;
		reset = 1;
		ce = 1;
		{host_sel, host_wr, host_addr, host_wdata, tx_pending, probe} = '0;
		mismatches = 0;
		n_compared = 0;
		void'($urandom(32'h4a12));
		repeat (2) @(posedge clk);
		#1 reset = 0;
		for (int i = 5; i < 8; i++) rd(BASE + 16'(16 * i + 13), 8'h00, 1'b1);
		for (int i = 0; i < 13; i++) f[i] = 8'($urandom);
		eng.rx_frame(f);
		@(posedge clk) #1 ce = 0;
		repeat (3) @(posedge clk);
		#1 ce = 1;
		for (int i = 0; i < 13; i++) img[4][i] = f[i];
		for (int i = 0; i < 128; i++) wr(7'(i), 8'($urandom));
		for (int i = 48; i < 128; i++) rd(BASE + 16'(i), want(7'(i)), i >= 64);
		rd(BASE + 16'h00c0, 8'h00, 1'b0);
		for (int k = 0; k < 12; k++) pick((k == 0) ? 3'b000 : 3'($urandom % 7 + 1), k);
		test_done();
	end
endmodule
